// ---- src/ccr_core_control.sv ----
/*
 core control register with an AXI4-Lite slave; 16-bit register in bits 15:0.
 assumes the core reports loop nesting, stack frame state and priority raises
 on the same clock, and takes the low three priority bits from the core but keeps the priority high bit itself.
*/
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps

// Overview of operation
// RQ1: bit 15 set selects variable exception latency, clear selects fixed latency.
// RQ2: bit 14 is not implemented, ignores writes and reads zero.
// RQ3: the sign field gives signed multiplies at 00, unsigned at 01, mixed at 10.
// RQ4: writing one to the early termination bit ends the active loop after this iteration.
// RQ5: the accumulator A saturation bit enables saturation of accumulator A.
// RQ6: the accumulator B saturation bit enables saturation of accumulator B.
// RQ7: the data write saturation bit saturates engine writes into data space.
// RQ8: the width select bit picks 9.31 saturation when set and 1.31 when clear.
// RQ9: the priority high bit sits above the three status priority bits to make a 4-bit level.
// RQ10: the early termination bit always reads zero.
// RQ11: the priority high bit reads one exactly when the level is above seven.
// RQ12: the rounding bit picks biased rounding when set and convergent when clear.
// RQ13: the multiplier mode bit picks integer mode when set and fractional when clear.
// RQ14: the nesting field is read only and shows how many loops are active, 0 to 7.
// RQ15: reset clears every bit but data write saturation, which sets; priority high only clears.
module ccr_core_control import ccr_pkg::*; (
	// clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// axi4-lite write channels
	input wire logic [3:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read channels
	input wire logic [3:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// core side
	input wire ccr_core_t coreState,
	input wire logic [2:0] prioLevelLowBits,
	output ccr_ctrl_t ctrl,
	output logic loopEarlyTerminate,
	output logic [3:0] prioLevel
);

	////////////////////////////////////////////////////////////////////
	logic [15:0] ctrlBits_reg;
	logic prioHigh_reg;
	logic earlyTerm_reg;
	logic awHeld_reg, wHeld_reg;
	logic [3:0] awAddr_reg;
	logic [31:0] wData_reg;
	logic [3:0] wStrb_reg;
	logic doWrite;
	logic [15:0] wordIn;
	logic [15:0] coreWord;

	function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] s);
		logic [15:0] r;
		r = old;
		if (s[0]) r[7:0] = d[7:0];
		if (s[1]) r[15:8] = d[15:8];
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////
	// write address and data taken in either order, response after both
	assign awready = !awHeld_reg && !bvalid;
	assign wready = !wHeld_reg && !bvalid;
	assign doWrite = awHeld_reg && wHeld_reg && !bvalid;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			awHeld_reg <= 1'b0;
			wHeld_reg <= 1'b0;
			awAddr_reg <= 4'h0;
			wData_reg <= 32'h0000_0000;
			wStrb_reg <= 4'h0;
		end else begin
			if (awvalid && awready) begin
				awHeld_reg <= 1'b1;
				awAddr_reg <= awaddr;
			end else if (doWrite) begin
				awHeld_reg <= 1'b0;
			end
			if (wvalid && wready) begin
				wHeld_reg <= 1'b1;
				wData_reg <= wdata;
				wStrb_reg <= wstrb;
			end else if (doWrite) begin
				wHeld_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			bvalid <= 1'b0;
			bresp <= CCR_RESP_OKAY;
		end else if (doWrite) begin
			bvalid <= 1'b1;
			bresp <= (awAddr_reg == CCR_ADDR_CORE_CONTROL) ? CCR_RESP_OKAY : CCR_RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// register fields
	assign wordIn = lane_merge(ctrlBits_reg, wData_reg, wStrb_reg);

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ctrlBits_reg <= CCR_RESET_CORE_CONTROL; // [RQ15]
		end else if (doWrite && awAddr_reg == CCR_ADDR_CORE_CONTROL) begin
			ctrlBits_reg <= wordIn;
			ctrlBits_reg[CCR_BIT_UNUSED] <= 1'b0; // [RQ2]
			ctrlBits_reg[CCR_BIT_EARLY_TERM] <= 1'b0; // [RQ10]
			ctrlBits_reg[CCR_BIT_NEST_HI:CCR_BIT_NEST_LO] <= 3'h0; // [RQ14]
			ctrlBits_reg[CCR_BIT_PRIO_HIGH] <= 1'b0;
			ctrlBits_reg[CCR_BIT_STACK_FRAME] <= 1'b0;
		end
	end

	// priority high: core raises, software may only clear; raise wins
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			prioHigh_reg <= 1'b0; // [RQ15]
		end else if (coreState.prioRaise) begin
			prioHigh_reg <= 1'b1; // [RQ11]
		end else if (doWrite && awAddr_reg == CCR_ADDR_CORE_CONTROL && wStrb_reg[0]
			&& !wData_reg[CCR_BIT_PRIO_HIGH]) begin
			prioHigh_reg <= 1'b0; // [RQ15]
		end
	end

	// one cycle termination request per written one
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			earlyTerm_reg <= 1'b0;
		end else begin
			earlyTerm_reg <= doWrite && awAddr_reg == CCR_ADDR_CORE_CONTROL && wStrb_reg[1]
				&& wData_reg[CCR_BIT_EARLY_TERM]; // [RQ4]
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs to the datapaths
	assign ctrl.varLatency = ctrlBits_reg[CCR_BIT_LATENCY]; // [RQ1]
	assign ctrl.mulSignMode = ccr_sign_t'(ctrlBits_reg[CCR_BIT_SIGN_HI:CCR_BIT_SIGN_LO]); // [RQ3]
	assign ctrl.accASatEn = ctrlBits_reg[CCR_BIT_SAT_A]; // [RQ5]
	assign ctrl.accBSatEn = ctrlBits_reg[CCR_BIT_SAT_B]; // [RQ6]
	assign ctrl.dataspaceWriteSatEn = ctrlBits_reg[CCR_BIT_SAT_DW]; // [RQ7]
	assign ctrl.satWidthSel = ctrlBits_reg[CCR_BIT_SAT_WIDTH]; // [RQ8]
	assign ctrl.roundingSel = ctrlBits_reg[CCR_BIT_ROUNDING]; // [RQ12]
	assign ctrl.intMulMode = ctrlBits_reg[CCR_BIT_INT_MODE]; // [RQ13]
	assign loopEarlyTerminate = earlyTerm_reg; // [RQ4]
	assign prioLevel = {prioHigh_reg, prioLevelLowBits}; // [RQ9]

	always_comb begin
		coreWord = ctrlBits_reg;
		coreWord[CCR_BIT_NEST_HI:CCR_BIT_NEST_LO] = coreState.loopNestCount; // [RQ14]
		coreWord[CCR_BIT_PRIO_HIGH] = prioHigh_reg; // [RQ11]
		coreWord[CCR_BIT_STACK_FRAME] = coreState.stackFrameActive;
	end

	////////////////////////////////////////////////////////////////////
	// read channel
	assign arready = !rvalid;

	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= CCR_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			unique case (araddr)
				CCR_ADDR_CORE_CONTROL: begin
					rdata <= {16'h0000, coreWord};
					rresp <= CCR_RESP_OKAY;
				end
				CCR_ADDR_SR_LOW: begin
					rdata <= {28'h0000000, prioHigh_reg, prioLevelLowBits};
					rresp <= CCR_RESP_OKAY;
				end
				default: begin
					rdata <= 32'h0000_0000;
					rresp <= CCR_RESP_SLVERR;
				end
			endcase
		end else if (rvalid && rready) begin
			rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	sequence s_ctrlWrite;
		doWrite && awAddr_reg == CCR_ADDR_CORE_CONTROL;
	endsequence

	a_unused_bit_zero: assert property (@(posedge clk_sys) disable iff (!nrst) // [RQ2]
		!ctrlBits_reg[CCR_BIT_UNUSED] && !coreWord[CCR_BIT_UNUSED])
		else $error("unimplemented bit set");
	a_early_term_reads: assert property (@(posedge clk_sys) disable iff (!nrst) // [RQ10]
		!coreWord[CCR_BIT_EARLY_TERM])
		else $error("early termination bit read as one");
	a_early_term_pulse: assert property (@(posedge clk_sys) disable iff (!nrst) // [RQ4]
		(s_ctrlWrite and wStrb_reg[1] && wData_reg[CCR_BIT_EARLY_TERM]) |=>
		loopEarlyTerminate ##1 !loopEarlyTerminate || $past(doWrite))
		else $error("termination request not one cycle");
	a_sat_a_follows: assert property (@(posedge clk_sys) disable iff (!nrst) // [RQ5]
		(s_ctrlWrite and wStrb_reg[0]) |=> ctrl.accASatEn == $past(wData_reg[CCR_BIT_SAT_A]))
		else $error("acc a saturation enable not written");
	a_latency_follows: assert property (@(posedge clk_sys) disable iff (!nrst) // [RQ1]
		(s_ctrlWrite and wStrb_reg[1]) |=> ctrl.varLatency == $past(wData_reg[CCR_BIT_LATENCY]))
		else $error("latency bit not written");
	a_prio_level_join: assert property (@(posedge clk_sys) disable iff (!nrst) // [RQ9]
		prioLevel[2:0] == prioLevelLowBits && prioLevel[3] == coreWord[CCR_BIT_PRIO_HIGH])
		else $error("priority level mismatch");
	a_prio_raise_wins: assert property (@(posedge clk_sys) disable iff (!nrst) // [RQ11]
		coreState.prioRaise |=> prioLevel > 4'h7)
		else $error("priority raise lost");
	a_prio_write_noset: assert property (@(posedge clk_sys) disable iff (!nrst) // [RQ15]
		(!prioHigh_reg && !coreState.prioRaise) |=> !prioHigh_reg)
		else $error("priority high set by software");
	a_nest_count_read: assert property (@(posedge clk_sys) disable iff (!nrst) // [RQ14]
		(arvalid && arready && araddr == CCR_ADDR_CORE_CONTROL) |=>
		rdata[CCR_BIT_NEST_HI:CCR_BIT_NEST_LO] == $past(coreState.loopNestCount))
		else $error("nesting count misread");
endmodule

// ---- src/ccr_pkg.sv ----
/*
 core control register package: byte offsets, bit positions, reset values,
 mode enumerations and the packed carriers for core side signals.
 assumes a 32-bit AXI4-Lite register bus and a 16-bit register in the low lanes.
*/
package ccr_pkg;
	localparam logic [3:0] CCR_ADDR_CORE_CONTROL = 4'h0;
	localparam logic [3:0] CCR_ADDR_SR_LOW = 4'h4;
	localparam int CCR_BIT_LATENCY = 15;
	localparam int CCR_BIT_UNUSED = 14;
	localparam int CCR_BIT_SIGN_HI = 13;
	localparam int CCR_BIT_SIGN_LO = 12;
	localparam int CCR_BIT_EARLY_TERM = 11;
	localparam int CCR_BIT_NEST_HI = 10;
	localparam int CCR_BIT_NEST_LO = 8;
	localparam int CCR_BIT_SAT_A = 7;
	localparam int CCR_BIT_SAT_B = 6;
	localparam int CCR_BIT_SAT_DW = 5;
	localparam int CCR_BIT_SAT_WIDTH = 4;
	localparam int CCR_BIT_PRIO_HIGH = 3;
	localparam int CCR_BIT_STACK_FRAME = 2;
	localparam int CCR_BIT_ROUNDING = 1;
	localparam int CCR_BIT_INT_MODE = 0;
	localparam logic [15:0] CCR_RESET_CORE_CONTROL = 16'h0020;
	localparam logic [1:0] CCR_RESP_OKAY = 2'h0;
	localparam logic [1:0] CCR_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MUL_SIGNED = 2'h0,
		MUL_UNSIGNED = 2'h1,
		MUL_MIXED = 2'h2
	} ccr_sign_t;

	// settings that steer the exception latency, multiplier, rounding and saturation datapaths
	typedef struct packed {
		logic varLatency;
		ccr_sign_t mulSignMode;
		logic accASatEn;
		logic accBSatEn;
		logic dataspaceWriteSatEn;
		logic satWidthSel;
		logic roundingSel;
		logic intMulMode;
	} ccr_ctrl_t;

	// state reported back by the core
	typedef struct packed {
		logic [2:0] loopNestCount;
		logic stackFrameActive;
		logic prioRaise;
	} ccr_core_t;
endpackage

// ---- testbench/dsp_core_control_register_test.sv ----
/*
 self-checking bench for the core control register behind its AXI4-Lite slave.
 assumes the slave and core side ports of ccr_core_control on one 20 MHz clock.
*/
`timescale 1ns/100ps
module dsp_core_control_register_test import ccr_pkg::*;;
	logic clk_sys = 1'b0, nrst = 1'b0;
	logic [3:0] awaddr = 4'h0, wstrb = 4'hF, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, loopEarlyTerminate;
	logic [1:0] bresp, rresp, rsp;
	logic [31:0] rd;
	ccr_core_t coreState = '0;
	logic [2:0] prioLevelLowBits = 3'h0;
	ccr_ctrl_t ctrl;
	logic [3:0] prioLevel;
	int fail_count = 0, checked = 0, cycles = 0, pulses = 0;
	ccr_core_control u_ccr_core_control (.clk_sys(clk_sys), .nrst(nrst), .awaddr(awaddr),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready), .coreState(coreState), .prioLevelLowBits(prioLevelLowBits),
		.ctrl(ctrl), .loopEarlyTerminate(loopEarlyTerminate), .prioLevel(prioLevel));
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (loopEarlyTerminate === 1'b1) pulses <= pulses + 1;
		if (cycles == 20000) begin
			fail_count = fail_count + 1;
			$display("FAIL %0t timeout waiting for the slave", $time);
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked = checked + 1;
		if (got !== exp) begin
			fail_count = fail_count + 1;
			$display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", fail_count, checked);
		if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// write: address and data offered together, each released when taken
	task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
		bit done;
		done = 0;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// each channel released only at the edge that takes it
		while (!done) begin
			@(posedge clk_sys);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				done = 1;
				rsp = bresp;
			end
		end
		bready <= 1'b0;
		chk(rsp, er, "write response");
	endtask
	task automatic axr(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
		bit done;
		done = 0;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done) begin
			@(posedge clk_sys);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				done = 1;
				rd = rdata;
				rsp = rresp;
			end
		end
		rready <= 1'b0;
		chk(rsp, er, "read response");
		chk(rd, ed, "read data");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		axr(4'h0, 32'h0000_0020, CCR_RESP_OKAY);
		chk(ctrl, 32'h008, "ctrl after reset");
		chk(prioLevel, 4'h0, "prio after reset");
	endtask
	task automatic t_fields();
		pulses = 0;
		axw(4'h0, 32'h0000_E8F3, CCR_RESP_OKAY);
		repeat (3) @(posedge clk_sys);
		chk(pulses, 1, "early stop pulse");
		axr(4'h0, 32'h0000_A0F3, CCR_RESP_OKAY);
		chk(ctrl, 32'h1BF, "ctrl all set");
		pulses = 0;
		axw(4'h0, 32'h0000_0000, CCR_RESP_OKAY);
		repeat (3) @(posedge clk_sys);
		chk(pulses, 0, "no pulse on zero");
		chk(ctrl, 32'h000, "ctrl all clear");
		for (int i = 0; i < 3; i++) begin
			axw(4'h0, 32'(i) << 12, CCR_RESP_OKAY);
			chk(ctrl.mulSignMode, 32'(i), "sign mode");
		end
	endtask
	task automatic t_nest();
		@(posedge clk_sys);
		coreState <= '{loopNestCount: 3'h5, stackFrameActive: 1'b1, prioRaise: 1'b0};
		axr(4'h0, 32'h0000_2504, CCR_RESP_OKAY);
		axw(4'h0, 32'h0000_0000, CCR_RESP_OKAY);
		axr(4'h0, 32'h0000_0504, CCR_RESP_OKAY);
		@(posedge clk_sys);
		coreState <= '0;
	endtask
	task automatic t_prio();
		@(posedge clk_sys);
		prioLevelLowBits <= 3'h5;
		axw(4'h0, 32'h0000_0008, CCR_RESP_OKAY);
		axr(4'h0, 32'h0000_0000, CCR_RESP_OKAY);
		chk(prioLevel, 4'h5, "level seven or less");
		coreState.prioRaise <= 1'b1;
		@(posedge clk_sys);
		coreState.prioRaise <= 1'b0;
		@(posedge clk_sys);
		@(negedge clk_sys);
		chk(prioLevel, 4'hD, "level above seven");
		axr(4'h0, 32'h0000_0008, CCR_RESP_OKAY);
		axw(4'h0, 32'h0000_0000, CCR_RESP_OKAY);
		@(negedge clk_sys);
		chk(prioLevel, 4'h5, "high bit cleared");
	endtask
	task automatic t_bad();
		axw(4'h0, 32'h0000_00F0, CCR_RESP_OKAY);
		axw(4'h8, 32'h0000_FFFF, CCR_RESP_SLVERR);
		axw(4'h4, 32'h0000_FFFF, CCR_RESP_SLVERR);
		axr(4'h8, 32'h0000_0000, CCR_RESP_SLVERR);
		axr(4'h4, 32'h0000_0005, CCR_RESP_OKAY);
		axr(4'h0, 32'h0000_00F0, CCR_RESP_OKAY);
	endtask
	// reset in mid-run with settings and the priority high bit set
	task automatic t_rerst();
		coreState.prioRaise <= 1'b1;
		@(posedge clk_sys);
		coreState.prioRaise <= 1'b0;
		nrst <= 1'b0;
		@(negedge clk_sys);
		chk(prioLevel, 4'hD, "raised before reset");
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		@(negedge clk_sys);
		chk(ctrl, 32'h008, "ctrl after second reset");
		chk(prioLevel, 4'h5, "prio after second reset");
		axr(4'h0, 32'h0000_0020, CCR_RESP_OKAY);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		t_reset();
		t_fields();
		t_nest();
		t_prio();
		t_bad();
		t_rerst();
		repeat (2) @(posedge clk_sys);
		report_and_stop();
	end
endmodule
